// File: design/sobd_cfg.svh
// constants for the secondary opcode and branch decoder
// assumes a 32-bit instruction word in the usual field layout
`ifndef SOBD_CFG_SVH
`define SOBD_CFG_SVH

// ****************************************************************
// instruction fields
// ****************************************************************
`define SOBD_F_OP 31:26
`define SOBD_F_RS 25:21
`define SOBD_F_RT 20:16
`define SOBD_F_RD 15:11
`define SOBD_F_FN 5:0
`define SOBD_F_IMM 15:0

// ****************************************************************
// primary opcodes that lead into the decoded groups
// ****************************************************************
`define SOBD_OP_SPECIAL 6'h00
`define SOBD_OP_REG_IMMEDIATE_GROUP 6'h01
`define SOBD_OP_BEQ 6'h04
`define SOBD_OP_BNE 6'h05
`define SOBD_OP_BRANCH_IF_NOT_POSITIVE 6'h06
`define SOBD_OP_BRANCH_IF_POSITIVE 6'h07
`define SOBD_OP_ADD_IMMEDIATE_TRAPPING 6'h08
`define SOBD_OP_ADD_IMMEDIATE_NONTRAPPING 6'h09
`define SOBD_OP_AND_WITH_IMMEDIATE 6'h0c
`define SOBD_OP_SYSCP 6'h10
`define SOBD_OP_BRANCH_IF_EQUAL_LIKELY 6'h14
`define SOBD_OP_BRANCH_IF_UNEQUAL_LIKELY 6'h15
`define SOBD_OP_BLEZL 6'h16
`define SOBD_OP_BGTZL 6'h17
`define SOBD_OP_EXTAR 6'h1c

// ****************************************************************
// function and field codes
// ****************************************************************
`define SOBD_FN_ADD 6'h20
`define SOBD_FN_ADDU 6'h21
`define SOBD_X_MACS 6'h00
`define SOBD_X_MACU 6'h01
`define SOBD_X_MULR 6'h02
`define SOBD_X_MDES 6'h04
`define SOBD_X_MDEU 6'h05
`define SOBD_X_CLZ 6'h20
`define SOBD_X_CLO 6'h21
`define SOBD_X_DBP 6'h3f
`define SOBD_RS_MF 5'h00
`define SOBD_RS_MT 5'h04
`define SOBD_C_XRD 6'h01
`define SOBD_C_XWI 6'h02
`define SOBD_C_XWR 6'h06
`define SOBD_C_XPR 6'h08
`define SOBD_C_EXCEPTION_RETURN 6'h18
`define SOBD_C_DRET 6'h1f
`define SOBD_C_WAIT 6'h20

// ****************************************************************
// link and branch figures
// ****************************************************************
`define SOBD_LINK_REG 5'h1f
`define SOBD_LINK_OFS 32'h0000_0008
`define SOBD_SLOT_OFS 32'h0000_0004
`define SOBD_ALL_BITS 6'h20

`endif

// File: design/sobd_decoder.sv
// secondary opcode and branch decoder, registered at stage boundary
// assumes operands, pc and saved debug pc arrive on clk from the core
//
// Contract
// - extended group: function row/column picks multiply, counts
// - immediate group rt: branches, traps, links; rest reserved
// - coprocessor rs: move from, move to, op group
// - op group returns, wait; buffer ops need buffer
// - unconditional branch is equal-compare of r0, taken
// - link idiom on r0 always takes and links
// - linking branches always write pc plus 8
// - likely branch not taken nullifies next instruction
// - sign conditions from bit 31 and zero test
// - immediate add to rt, and-immediate zero-extends
// - debug return loads saved pc, exits debug
// - reserved encodings raise reserved-instruction exception
// - leading counts scan downward, 32 when uniform
`timescale 1ns/10ps
`include "sobd_cfg.svh"
module sobd_decoder (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [31:0] rs_val,
    input wire logic [31:0] rt_val,
    input wire logic [31:0] pc,
    input wire logic [31:0] debug_saved_pc,
    input wire logic xlate_present,
    output sobd_pkg::sobd_dec_type dec_q,
    output logic dec_valid_q
);
    // ****************************************************************
    // field extraction
    // ****************************************************************
    wire [5:0] opc = instr[`SOBD_F_OP];
    wire [4:0] rs_f = instr[`SOBD_F_RS];
    wire [4:0] rt_f = instr[`SOBD_F_RT];
    wire [4:0] rd_f = instr[`SOBD_F_RD];
    wire [5:0] fn = instr[`SOBD_F_FN];
    wire [15:0] imm = instr[`SOBD_F_IMM];
    wire [31:0] simm = {{16{imm[15]}}, imm};
    wire [31:0] zimm = {16'h0000, imm};
    // register zero reads as zero whatever the file hands us
    wire [31:0] rs_e = (rs_f == 5'h00) ? 32'h0 : rs_val;
    wire [31:0] rt_e = (rt_f == 5'h00) ? 32'h0 : rt_val;

    // ****************************************************************
    // group selects
    // ****************************************************************
    wire g_ext = (opc == `SOBD_OP_EXTAR);
    wire g_rim = (opc == `SOBD_OP_REG_IMMEDIATE_GROUP);
    wire g_scp = (opc == `SOBD_OP_SYSCP);
    wire g_beq = (opc == `SOBD_OP_BEQ) || (opc == `SOBD_OP_BRANCH_IF_EQUAL_LIKELY);
    wire g_bne = (opc == `SOBD_OP_BNE) || (opc == `SOBD_OP_BRANCH_IF_UNEQUAL_LIKELY);
    wire g_branch_if_not_positive = (opc == `SOBD_OP_BRANCH_IF_NOT_POSITIVE) || (opc == `SOBD_OP_BLEZL);
    wire g_branch_if_positive = (opc == `SOBD_OP_BRANCH_IF_POSITIVE) || (opc == `SOBD_OP_BGTZL);
    wire g_pri_br = g_beq || g_bne || g_branch_if_not_positive || g_branch_if_positive;
    wire pri_likely = g_pri_br && opc[4];
    wire g_add_immediate_trapping = (opc == `SOBD_OP_ADD_IMMEDIATE_TRAPPING) || (opc == `SOBD_OP_ADD_IMMEDIATE_NONTRAPPING);
    wire g_and_with_immediate = (opc == `SOBD_OP_AND_WITH_IMMEDIATE);
    wire g_addr = (opc == `SOBD_OP_SPECIAL)
        && ((fn == `SOBD_FN_ADD) || (fn == `SOBD_FN_ADDU));

    // ****************************************************************
    // sign-based and equality conditions
    // ****************************************************************
    wire rs_zero = (rs_e == 32'h0);
    wire c_gez = ~rs_e[31];
    wire c_ltz = rs_e[31];
    wire c_gtz = ~rs_e[31] && !rs_zero;
    wire c_lez = rs_e[31] || rs_zero;
    wire c_eq = (rs_e == rt_e);

    // immediate group rows: 00 branch, 01 trap, 10 link
    wire rim_br = g_rim && (rt_f[4:3] == 2'b00) && !rt_f[2];
    wire rim_lk = g_rim && (rt_f[4:3] == 2'b10) && !rt_f[2];
    wire rim_tr = g_rim && (rt_f[4:3] == 2'b01)
        && ((rt_f[2:0] <= 3'h4) || (rt_f[2:0] == 3'h6));
    wire rim_c = rt_f[0] ? c_gez : c_ltz;

    wire br_any = g_pri_br || rim_br || rim_lk;
    wire br_likely = pri_likely || ((rim_br || rim_lk) && rt_f[1]);
    wire br_cond = g_beq ? c_eq : g_bne ? !c_eq : g_branch_if_not_positive ? c_lez
        : g_branch_if_positive ? c_gtz : rim_c;

    // immediate trap compares
    wire t_ges = ($signed(rs_e) >= $signed(simm));
    wire t_geu = (rs_e >= simm);
    wire [2:0] tsel = rt_f[2:0];
    wire t_cond = (tsel == 3'h0) ? t_ges : (tsel == 3'h1) ? t_geu
        : (tsel == 3'h2) ? !t_ges : (tsel == 3'h3) ? !t_geu
        : (tsel == 3'h4) ? (rs_e == simm) : (rs_e != simm);

    // ****************************************************************
    // extended group and coprocessor op decode
    // ****************************************************************
    wire x_mac_s = g_ext && (fn == `SOBD_X_MACS);
    wire x_mac_u = g_ext && (fn == `SOBD_X_MACU);
    wire x_mul_r = g_ext && (fn == `SOBD_X_MULR);
    wire x_mde_s = g_ext && (fn == `SOBD_X_MDES);
    wire x_mde_u = g_ext && (fn == `SOBD_X_MDEU);
    wire x_clz = g_ext && (fn == `SOBD_X_CLZ);
    wire x_clo = g_ext && (fn == `SOBD_X_CLO);
    wire x_dbp = g_ext && (fn == `SOBD_X_DBP);
    wire s_mf = g_scp && (rs_f == `SOBD_RS_MF);
    wire s_mt = g_scp && (rs_f == `SOBD_RS_MT);
    wire s_co = g_scp && rs_f[4];
    // buffer ops stay reserved on parts built without the buffer
    wire c_xrd = s_co && xlate_present && (fn == `SOBD_C_XRD);
    wire c_xwi = s_co && xlate_present && (fn == `SOBD_C_XWI);
    wire c_xwr = s_co && xlate_present && (fn == `SOBD_C_XWR);
    wire c_xpr = s_co && xlate_present && (fn == `SOBD_C_XPR);
    wire c_exception_return = s_co && (fn == `SOBD_C_EXCEPTION_RETURN);
    wire c_dret = s_co && (fn == `SOBD_C_DRET);
    wire c_wait = s_co && (fn == `SOBD_C_WAIT);

    wire ext_ok = x_mac_s || x_mac_u || x_mul_r || x_mde_s || x_mde_u
        || x_clz || x_clo || x_dbp;
    wire co_ok = c_xrd || c_xwi || c_xwr || c_xpr || c_exception_return || c_dret
        || c_wait;
    // anything inside a decoded group that matched nothing is reserved
    wire rsvd = (g_ext && !ext_ok)
        || (g_rim && !(rim_br || rim_lk || rim_tr))
        || (g_scp && !(s_mf || s_mt || (s_co && co_ok)));

    // ****************************************************************
    // datapath results
    // ****************************************************************
    logic [5:0] lead_cnt;
    sobd_lead_count sobd_lead_count_inst (
        .value(rs_e),
        .count_ones(x_clo),
        .count(lead_cnt)
    );
    wire [31:0] sum_i = rs_e + simm;
    wire [31:0] sum_r = rs_e + rt_e;
    wire [31:0] prod = rs_e * rt_e;
    wire ovf_i = (opc == `SOBD_OP_ADD_IMMEDIATE_TRAPPING) && (rs_e[31] == simm[31])
        && (sum_i[31] != rs_e[31]);
    wire ovf_r = g_addr && (fn == `SOBD_FN_ADD)
        && (rs_e[31] == rt_e[31]) && (sum_r[31] != rs_e[31]);
    wire ovf = ovf_i || ovf_r;
    wire [31:0] link_val = pc + `SOBD_LINK_OFS;
    wire [31:0] br_tgt = pc + `SOBD_SLOT_OFS
        + {simm[29:0], 2'b00};

    // ****************************************************************
    // combinational decode, captured at the stage boundary
    // ****************************************************************
    sobd_pkg::sobd_dec_type dec_d;
    always_comb begin
        dec_d = '0;
        dec_d.op = sobd_pkg::SOBD_NONE;
        if (rsvd) begin
            dec_d.op = sobd_pkg::SOBD_RSVD;
            dec_d.reserved = 1'b1;
        end else if (br_any) begin
            dec_d.op = sobd_pkg::SOBD_BRANCH;
            dec_d.branch = 1'b1;
            dec_d.taken = br_cond;
            dec_d.likely = br_likely;
            dec_d.nullify = br_likely && !br_cond;
            dec_d.pc_load = br_cond;
            dec_d.pc_value = br_tgt;
            dec_d.link = rim_lk;
            dec_d.wr_en = rim_lk;
            dec_d.wr_addr = rim_lk ? `SOBD_LINK_REG : 5'h00;
            dec_d.wr_data = rim_lk ? link_val : 32'h0;
        end else if (rim_tr) begin
            dec_d.op = sobd_pkg::SOBD_TRAP_I;
            dec_d.trap = t_cond;
        end else if (g_add_immediate_trapping || g_addr) begin
            dec_d.op = g_add_immediate_trapping ? sobd_pkg::SOBD_ADD_IMM
                : sobd_pkg::SOBD_ADD_REG;
            dec_d.overflow = ovf;
            dec_d.wr_en = !ovf;
            dec_d.wr_addr = g_add_immediate_trapping ? rt_f : rd_f;
            dec_d.wr_data = g_add_immediate_trapping ? sum_i : sum_r;
        end else if (g_and_with_immediate) begin
            dec_d.op = sobd_pkg::SOBD_AND_IMM;
            dec_d.wr_en = 1'b1;
            dec_d.wr_addr = rt_f;
            dec_d.wr_data = rs_e & zimm;
        end else if (x_clz || x_clo) begin
            dec_d.op = x_clz ? sobd_pkg::SOBD_CLZ : sobd_pkg::SOBD_CLO;
            dec_d.wr_en = 1'b1;
            dec_d.wr_addr = rd_f;
            dec_d.wr_data = {26'h0, lead_cnt};
        end else if (x_mul_r) begin
            dec_d.op = sobd_pkg::SOBD_MUL_R;
            dec_d.wr_en = 1'b1;
            dec_d.wr_addr = rd_f;
            dec_d.wr_data = prod;
        end else if (c_dret) begin
            dec_d.op = sobd_pkg::SOBD_DBG_RET;
            dec_d.pc_load = 1'b1;
            dec_d.pc_value = debug_saved_pc;
            dec_d.debug_exit = 1'b1;
        end else begin
            dec_d.op = x_mac_s ? sobd_pkg::SOBD_MAC_S
                : x_mac_u ? sobd_pkg::SOBD_MAC_U
                : x_mde_s ? sobd_pkg::SOBD_MDE_S
                : x_mde_u ? sobd_pkg::SOBD_MDE_U
                : x_dbp ? sobd_pkg::SOBD_DBG_BP
                : s_mf ? sobd_pkg::SOBD_MOVE_FROM
                : s_mt ? sobd_pkg::SOBD_MOVE_TO
                : c_xrd ? sobd_pkg::SOBD_XB_READ
                : c_xwi ? sobd_pkg::SOBD_XB_WR_IDX
                : c_xwr ? sobd_pkg::SOBD_XB_WR_RND
                : c_xpr ? sobd_pkg::SOBD_XB_PROBE
                : c_exception_return ? sobd_pkg::SOBD_EXC_RET
                : c_wait ? sobd_pkg::SOBD_WAIT
                : sobd_pkg::SOBD_NONE;
        end
    end

    // stage register; a bubble clears the result so nothing acts twice
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dec_q <= '0;
            dec_valid_q <= 1'b0;
        end else if (ce) begin
            dec_q <= instr_valid ? dec_d : '0;
            dec_valid_q <= instr_valid;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_take(logic c);
        ce && instr_valid && c;
    endsequence

    sequence s_link_out(logic [31:0] v);
        dec_q.link && dec_q.wr_en && dec_q.wr_addr == 5'h1f
            && dec_q.wr_data == v;
    endsequence

    ext_signed_mul_accumulate_a: assert property (s_take(g_ext && fn == 6'h00)
        |=> dec_q.op == sobd_pkg::SOBD_MAC_S)
        else $error("multiply-add not decoded");
    rim_rsvd_a: assert property (s_take(g_rim && rt_f[4:3] == 2'b11)
        |=> dec_q.reserved && !dec_q.branch)
        else $error("immediate group row 11 not reserved");
    scp_mt_a: assert property (s_take(g_scp && rs_f == 5'h04)
        |=> dec_q.op == sobd_pkg::SOBD_MOVE_TO)
        else $error("move-to not decoded");
    xb_absent_a: assert property (s_take(s_co && !xlate_present
        && fn == 6'h01) |=> dec_q.reserved)
        else $error("buffer read decoded without buffer");
    br_always_a: assert property (s_take(opc == 6'h04 && rs_f == 5'h00
        && rt_f == 5'h00) |=> dec_q.taken && dec_q.pc_value
        == $past(pc) + 32'h4 + {$past(simm[29:0]), 2'b00})
        else $error("r0 equal branch not taken to target");
    link_always_a: assert property (s_take(rim_lk && rs_f == 5'h00
        && rt_f[0]) |=> dec_q.taken && dec_q.link)
        else $error("r0 link idiom not taken");
    link_write_a: assert property (s_take(rim_lk)
        |=> s_link_out($past(pc) + 32'h8))
        else $error("link value missing");
    likely_null_a: assert property (s_take(br_any && br_likely
        && !br_cond) |=> dec_q.nullify && !dec_q.pc_load ##1 1'b1)
        else $error("likely not-taken did not nullify");
    gtz_cond_a: assert property (s_take(opc == 6'h07)
        |=> dec_q.taken == (!$past(rs_e[31]) && $past(rs_e) != 32'h0))
        else $error("positive branch condition wrong");
    and_with_immediate_zext_a: assert property (s_take(g_and_with_immediate)
        |=> dec_q.wr_data[31:16] == 16'h0 && dec_q.wr_addr == $past(rt_f))
        else $error("and-immediate not zero-extended");
    dret_pc_a: assert property (s_take(c_dret)
        |=> dec_q.pc_load && dec_q.debug_exit
            && dec_q.pc_value == $past(debug_saved_pc))
        else $error("debug return pc wrong");
    rsvd_quiet_a: assert property (dec_q.reserved
        |-> !dec_q.wr_en && !dec_q.pc_load && !dec_q.trap)
        else $error("reserved instruction still acted");
    clz_full_a: assert property (s_take(x_clz && rs_e == 32'h0)
        |=> dec_q.wr_data == 32'h20)
        else $error("leading zero count of zero not 32");
    stage_lat_a: assert property (ce && instr_valid
        |=> dec_valid_q)
        else $error("decode result late");
endmodule : sobd_decoder

// File: design/sobd_lead_count.sv
// leading ones or zeros counter for a 32-bit word
// assumes purely combinational use inside the decoder
`timescale 1ns/10ps
module sobd_lead_count (
    input wire logic [31:0] value,
    input wire logic count_ones,
    output logic [5:0] count
);
    logic [31:0] run;

    // a bit counts only while every bit above it matched too
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_run
            if (gi == 31) begin : g_top
                assign run[gi] = ~(value[gi] ^ count_ones);
            end else begin : g_rest
                assign run[gi] = run[gi+1] & ~(value[gi] ^ count_ones);
            end
        end
    endgenerate

    // population of the run gives 32 when all bits match
    always_comb begin
        count = 6'h00;
        for (int i = 0; i < 32; i++) begin
            count = count + {5'h00, run[i]};
        end
    end
endmodule : sobd_lead_count

// File: design/sobd_pkg.sv
// types shared by the decoder files
// assumes sobd_cfg.svh carries the numbers
package sobd_pkg;

    // ****************************************************************
    // operation classes
    // ****************************************************************
    typedef enum logic [4:0] {
        SOBD_NONE = 5'b00000,
        SOBD_MAC_S = 5'b00001,
        SOBD_MAC_U = 5'b00010,
        SOBD_MUL_R = 5'b00011,
        SOBD_MDE_S = 5'b00100,
        SOBD_MDE_U = 5'b00101,
        SOBD_CLZ = 5'b00110,
        SOBD_CLO = 5'b00111,
        SOBD_DBG_BP = 5'b01000,
        SOBD_BRANCH = 5'b01001,
        SOBD_TRAP_I = 5'b01010,
        SOBD_MOVE_FROM = 5'b01011,
        SOBD_MOVE_TO = 5'b01100,
        SOBD_XB_READ = 5'b01101,
        SOBD_XB_WR_IDX = 5'b01110,
        SOBD_XB_WR_RND = 5'b01111,
        SOBD_XB_PROBE = 5'b10000,
        SOBD_EXC_RET = 5'b10001,
        SOBD_DBG_RET = 5'b10010,
        SOBD_WAIT = 5'b10011,
        SOBD_ADD_IMM = 5'b10100,
        SOBD_AND_IMM = 5'b10101,
        SOBD_ADD_REG = 5'b10110,
        SOBD_RSVD = 5'b10111
    } sobd_op_type;

    // ****************************************************************
    // decode result handed to execute
    // ****************************************************************
    typedef struct packed {
        sobd_op_type op;
        logic reserved;
        logic branch;
        logic taken;
        logic likely;
        logic nullify;
        logic link;
        logic wr_en;
        logic [4:0] wr_addr;
        logic [31:0] wr_data;
        logic pc_load;
        logic [31:0] pc_value;
        logic trap;
        logic overflow;
        logic debug_exit;
    } sobd_dec_type;

endpackage : sobd_pkg

// File: tb/sobd_decoder_test.sv
// self-checking bench for the decoder
// assumes the fetch model drives the instruction side
`timescale 1ns/10ps
`include "sobd_cfg.svh"
module sobd_decoder_test;
    // ************************************************
    // harness
    // ************************************************
    localparam logic [31:0] pc0 = 32'h0000_1000;
    localparam logic [10:0] f_rsv = 11'h400, f_br = 11'h200;
    localparam logic [10:0] f_tk = 11'h100, f_lk = 11'h080;
    localparam logic [10:0] f_nul = 11'h040, f_lnk = 11'h020;
    localparam logic [10:0] f_wen = 11'h010, f_pcl = 11'h008;
    localparam logic [10:0] f_trp = 11'h004, f_ovf = 11'h002;
    logic clk, rstn, ce, xlate_present, instr_valid, dec_valid_q;
    logic [31:0] instr, rs_val, rt_val, pc;
    logic [31:0] dpc = 32'h0000_2000;
    sobd_pkg::sobd_dec_type dec_q;
    int err_total = 0;
    int tests_run = 0;
    wire logic [10:0] fl = {dec_q.reserved, dec_q.branch, dec_q.taken,
        dec_q.likely, dec_q.nullify, dec_q.link, dec_q.wr_en,
        dec_q.pc_load, dec_q.trap, dec_q.overflow, dec_q.debug_exit};

    sobd_fetch_model sobd_fetch_model_inst (.clk(clk),
        .instr_valid(instr_valid), .instr(instr), .rs_val(rs_val),
        .rt_val(rt_val), .pc(pc));
    sobd_decoder sobd_decoder_inst (.clk(clk), .rstn(rstn), .ce(ce),
        .instr_valid(instr_valid), .instr(instr), .rs_val(rs_val),
        .rt_val(rt_val), .pc(pc), .debug_saved_pc(dpc),
        .xlate_present(xlate_present), .dec_q(dec_q),
        .dec_valid_q(dec_valid_q));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // result shows exactly one edge after the word is driven
    task automatic run(input logic [31:0] w, input logic [31:0] a,
        input logic [31:0] b, input sobd_pkg::sobd_op_type op,
        input logic [10:0] ef);
        sobd_fetch_model_inst.issue(w, a, b, pc0);
        #1;
        chk("valid", 32'h1, {31'h0, dec_valid_q});
        chk("op", {27'h0, op}, {27'h0, dec_q.op});
        chk("flags", {21'h0, ef}, {21'h0, fl});
    endtask : run

    function automatic logic [31:0] enc(input logic [5:0] op,
        input logic [4:0] rs, input logic [4:0] rt, input logic [15:0] i);
        return {op, rs, rt, i};
    endfunction : enc

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_ext();
        logic [5:0] fn [7] = '{`SOBD_X_MACS, `SOBD_X_MACU, `SOBD_X_MDES,
            `SOBD_X_MDEU, `SOBD_X_DBP, 6'h03, 6'h22};
        sobd_pkg::sobd_op_type o [7] = '{sobd_pkg::SOBD_MAC_S,
            sobd_pkg::SOBD_MAC_U, sobd_pkg::SOBD_MDE_S, sobd_pkg::SOBD_MDE_U,
            sobd_pkg::SOBD_DBG_BP, sobd_pkg::SOBD_RSVD, sobd_pkg::SOBD_RSVD};
        logic [31:0] v [4] = '{32'h0, 32'h0001_0000, '1, 32'hf000_0000};
        logic [31:0] n [4] = '{32'h20, 32'hf, 32'h20, 32'h4};
        for (int i = 0; i < 7; i++) begin
            run(enc(`SOBD_OP_EXTAR, 5'h2, 5'h3, {5'h4, 5'h0, fn[i]}), 1, 1,
                o[i], (i > 4) ? f_rsv : 11'h0);
        end
        run(enc(`SOBD_OP_EXTAR, 5'h2, 5'h3, {5'h4, 5'h0, `SOBD_X_MULR}),
            32'h3, 32'hffff_fffe, sobd_pkg::SOBD_MUL_R, f_wen);
        chk("mul", 32'hffff_fffa, dec_q.wr_data);
        // counts of 32 and of a partial run, zeros then ones
        for (int i = 0; i < 4; i++) begin
            run(enc(`SOBD_OP_EXTAR, 5'h2, 5'h0, {5'h4, 5'h0, i > 1 ?
                `SOBD_X_CLO : `SOBD_X_CLZ}), v[i], 0, i > 1 ?
                sobd_pkg::SOBD_CLO : sobd_pkg::SOBD_CLZ, f_wen);
            chk("count", n[i], dec_q.wr_data);
        end
    endtask : t_ext

    task automatic t_reg_immediate_group();
        logic [4:0] rt [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h13,
            5'h05, 5'h18, 5'h08};
        logic [31:0] a [9] = '{'1, '1, 1, 1, 1, '1, 1, 1, 5};
        logic [10:0] e [9] = '{f_br | f_tk | f_pcl, f_br, f_br | f_lk |
            f_nul, f_br | f_tk | f_lk | f_pcl, f_br | f_lnk | f_wen, f_br |
            f_lk | f_nul | f_lnk | f_wen, f_rsv, f_rsv, f_trp};
        for (int i = 0; i < 9; i++) begin
            run(enc(`SOBD_OP_REG_IMMEDIATE_GROUP, 5'h2, rt[i], 16'h5), a[i], 0, i > 7 ?
                sobd_pkg::SOBD_TRAP_I : i > 5 ? sobd_pkg::SOBD_RSVD :
                sobd_pkg::SOBD_BRANCH, e[i]);
            if (e[i][3]) chk("target", pc0 + 32'h18, dec_q.pc_value);
            if (e[i][5]) chk("link", pc0 + 32'h8, dec_q.wr_data);
            if (e[i][5]) chk("lreg", 32'h1f, {27'h0, dec_q.wr_addr});
        end
        // equal-immediate trap with unequal operands must stay quiet
        run(enc(`SOBD_OP_REG_IMMEDIATE_GROUP, 5'h2, 5'h0c, 16'h5), 4, 0,
            sobd_pkg::SOBD_TRAP_I, 11'h0);
    endtask : t_reg_immediate_group

    // r0 idioms must ignore the operand buses; then a zero r2 for the sign branches
    task automatic t_idiom();
        run(enc(`SOBD_OP_BEQ, 5'h0, 5'h0, 16'hfffe), 32'h12, 32'h34,
            sobd_pkg::SOBD_BRANCH, f_br | f_tk | f_pcl);
        chk("back", pc0 - 32'h4, dec_q.pc_value);
        run(enc(`SOBD_OP_REG_IMMEDIATE_GROUP, 5'h0, 5'h11, 16'h1), '1, 0,
            sobd_pkg::SOBD_BRANCH, f_br | f_tk | f_pcl | f_lnk | f_wen);
        run(enc(`SOBD_OP_BRANCH_IF_POSITIVE, 5'h2, 5'h0, 16'h1), 0, 0,
            sobd_pkg::SOBD_BRANCH, f_br);
        run(enc(`SOBD_OP_BRANCH_IF_NOT_POSITIVE, 5'h2, 5'h0, 16'h1), 0, 0,
            sobd_pkg::SOBD_BRANCH, f_br | f_tk | f_pcl);
    endtask : t_idiom

    task automatic t_cop();
        run(enc(`SOBD_OP_SYSCP, `SOBD_RS_MF, 5'h1, 16'h0), 0, 0,
            sobd_pkg::SOBD_MOVE_FROM, 11'h0);
        run(enc(`SOBD_OP_SYSCP, `SOBD_RS_MT, 5'h1, 16'h0), 0, 0,
            sobd_pkg::SOBD_MOVE_TO, 11'h0);
        run(enc(`SOBD_OP_SYSCP, 5'h01, 5'h1, 16'h0), 0, 0,
            sobd_pkg::SOBD_RSVD, f_rsv);
        run(enc(`SOBD_OP_SYSCP, 5'h10, 5'h0, {10'h0, `SOBD_C_DRET}), 0, 0,
            sobd_pkg::SOBD_DBG_RET, f_pcl | 11'h001);
        chk("dpc", dpc, dec_q.pc_value);
        run(enc(`SOBD_OP_SYSCP, 5'h10, 5'h0, {10'h0, `SOBD_C_EXCEPTION_RETURN}), 0, 0,
            sobd_pkg::SOBD_EXC_RET, 11'h0);
        run(enc(`SOBD_OP_SYSCP, 5'h10, 5'h0, {10'h0, `SOBD_C_WAIT}), 0, 0,
            sobd_pkg::SOBD_WAIT, 11'h0);
        run(enc(`SOBD_OP_SYSCP, 5'h10, 5'h0, {10'h0, `SOBD_C_XPR}), 0, 0,
            sobd_pkg::SOBD_XB_PROBE, 11'h0);
        @(posedge clk);
        xlate_present <= 1'b0;
        run(enc(`SOBD_OP_SYSCP, 5'h10, 5'h0, {10'h0, `SOBD_C_XPR}), 0, 0,
            sobd_pkg::SOBD_RSVD, f_rsv);
        @(posedge clk);
        xlate_present <= 1'b1;
    endtask : t_cop

    task automatic t_arith();
        run(enc(`SOBD_OP_ADD_IMMEDIATE_NONTRAPPING, 5'h2, 5'h3, 16'hfffe), 5, 0,
            sobd_pkg::SOBD_ADD_IMM, f_wen);
        chk("sum", 32'h3, dec_q.wr_data);
        chk("rt", 32'h3, {27'h0, dec_q.wr_addr});
        run(enc(`SOBD_OP_AND_WITH_IMMEDIATE, 5'h2, 5'h3, 16'h8001), '1, 0,
            sobd_pkg::SOBD_AND_IMM, f_wen);
        chk("and", 32'h8001, dec_q.wr_data);
        run(enc(`SOBD_OP_ADD_IMMEDIATE_TRAPPING, 5'h2, 5'h3, 16'h1), 32'h7fff_ffff, 0,
            sobd_pkg::SOBD_ADD_IMM, f_ovf);
        // register form lands in rd, not rt
        run(enc(`SOBD_OP_SPECIAL, 5'h2, 5'h3, {5'h4, 5'h0, `SOBD_FN_ADDU}),
            5, 7, sobd_pkg::SOBD_ADD_REG, f_wen);
        chk("sumr", 32'hc, dec_q.wr_data);
        chk("rd", 32'h4, {27'h0, dec_q.wr_addr});
    endtask : t_arith

    // the idle word is taken one edge later; a frozen edge takes none
    task automatic t_timing();
        @(posedge clk);
        #1;
        chk("idle", 32'h0, {31'h0, dec_valid_q});
        @(posedge clk);
        ce <= 1'b0;
        sobd_fetch_model_inst.issue(32'h1000_0000, 0, 0, pc0);
        #1;
        chk("frozen", 32'h0, {31'h0, dec_valid_q});
        @(posedge clk);
        ce <= 1'b1;
    endtask : t_timing

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        xlate_present = 1'b1;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("rst", 32'h0, {16'h0, dec_valid_q, dec_q.op, fl[10:1]});
        t_ext();
        t_reg_immediate_group();
        t_idiom();
        t_cop();
        t_arith();
        t_timing();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule : sobd_decoder_test

// File: tb/sobd_fetch_model.sv
// fetch-side model: presents one word with its operands
// assumes the caller waits for issue to return before the next
`timescale 1ns/10ps
module sobd_fetch_model (
    input wire logic clk,
    output logic instr_valid,
    output logic [31:0] instr,
    output logic [31:0] rs_val,
    output logic [31:0] rt_val,
    output logic [31:0] pc
);
    // ************************************************
    // issue path
    // ************************************************
    initial begin
        {instr_valid, instr, rs_val, rt_val, pc} = '0;
    end

    // released lines show the inverse, so stale data never passes
    task automatic issue(input logic [31:0] w, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] p);
        @(posedge clk);
        instr_valid <= 1'b1;
        {instr, rs_val, rt_val, pc} <= {w, a, b, p};
        @(posedge clk);
        instr_valid <= 1'b0;
        {instr, rs_val, rt_val, pc} <= ~{w, a, b, p};
    endtask : issue
endmodule : sobd_fetch_model
